/* logic/adc_reset_dma_monitor_ctrl.sv */
// converter control slice: software reset key, dma trigger gating, comparison monitor 0
// assumes an apb master on pclk
// one-cycle completion events and request pulses
`include "adc_ctrl_defines.svh"
module adc_reset_dma_monitor_ctrl #(
    parameter int RESULT_W    = 12,
    parameter int INIT_CYCLES = `INIT_CYCLES
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,

    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,

    // converter core
    input  wire adc_ctrl_pkg::conv_event_t conv_event,
    input  wire logic                      repeat_mode_active,
    input  wire logic [RESULT_W-1:0]       compare_value,
    input  wire logic                      conv_start_req,
    output logic                           conv_start_grant,
    output logic                           converter_soft_reset,
    output logic                           init_busy,

    // dma controller
    output logic                           normal_dma_req,
    output logic                           top_priority_dma_req,

    // interrupts
    output logic                           monitor0_hit,
    output logic                           irq
);

    // ------------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------------

    if (INIT_CYCLES < 1) begin : g_bad_init
        $error("init cycle count must be at least one");
    end

    if (RESULT_W < 1 || RESULT_W > 12) begin : g_bad_result
        $error("result width must be 1 to 12");
    end

    // ------------------------------------------------------------------------
    // apb phase decode
    // ------------------------------------------------------------------------

    wire setup_phase  = psel && !penable;

    wire access_phase = psel && penable;

    wire wr_access    = access_phase && pwrite;

    wire hit_soft_reset = (paddr == `OFS_SOFT_RESET);

    wire hit_dma        = (paddr == `OFS_DMA_TRIGGER);

    wire hit_mon0       = (paddr == `OFS_MON0_CONTROL);

    wire hit_status     = (paddr == `OFS_IRQ_STATUS);

    wire hit_mask       = (paddr == `OFS_IRQ_MASK);

    wire hit_state      = (paddr == `OFS_BLOCK_STATE);

    wire mapped         = hit_soft_reset || hit_dma || hit_mon0
                       || hit_status || hit_mask || hit_state;

    wire wr_soft_reset = wr_access && hit_soft_reset;

    wire wr_dma        = wr_access && hit_dma;

    wire wr_mon0       = wr_access && hit_mon0;

    wire wr_status     = wr_access && hit_status;

    wire wr_mask       = wr_access && hit_mask;

    // ------------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------------

    logic [3:0]                dma_trigger_reg;
    logic [3:0]                dma_trigger_next;

    logic [11:0]               mon0_control_reg;
    logic [11:0]               mon0_control_next;

    logic [`IRQ_BITS-1:0]      irq_status_reg;
    logic [`IRQ_BITS-1:0]      irq_status_next;

    logic [`IRQ_BITS-1:0]      irq_mask_reg;
    logic [`IRQ_BITS-1:0]      irq_mask_next;

    logic [31:0]               prdata_reg;
    logic [31:0]               prdata_next;

    adc_ctrl_pkg::key_state_t  key_reg;
    adc_ctrl_pkg::key_state_t  key_next;

    logic                      soft_reset_reg;
    logic                      soft_reset_next;

    logic                      normal_dma_reg;
    logic                      top_dma_reg;

    // ------------------------------------------------------------------------
    // field views
    // ------------------------------------------------------------------------

    wire       mon0_enable    = mon0_control_reg[`MON_EN_BIT];
    wire       mon0_small_sel = mon0_control_reg[`MON_SEL_BIT];
    wire [3:0] mon0_chan_sel  = mon0_control_reg[`MON_CHAN_MSB:`MON_CHAN_LSB];
    wire [3:0] mon0_match_cnt = mon0_control_reg[`MON_CNT_MSB:`MON_CNT_LSB];

    wire       normal_dma_en  = dma_trigger_reg[`DMA_NORMAL_BIT];
    wire       top_dma_en     = dma_trigger_reg[`DMA_TOP_BIT];

    wire [1:0] key_value      = pwdata[`KEY_MSB:`KEY_LSB];

    // ------------------------------------------------------------------------
    // submodule results
    // ------------------------------------------------------------------------

    logic       init_busy_w;
    logic       init_done_w;

    logic [4:0] mon0_count_w;
    logic       mon0_hit_w;

    // ------------------------------------------------------------------------
    // software reset key sequencer
    // ------------------------------------------------------------------------
    always_comb begin
        key_next        = key_reg;
        soft_reset_next = 1'b0;

        case (key_reg)
            adc_ctrl_pkg::KEY_IDLE: begin
                if (wr_soft_reset && key_value == `KEY_FIRST) begin
                    key_next = adc_ctrl_pkg::KEY_ARMED;
                end
            end

            adc_ctrl_pkg::KEY_ARMED: begin
                if (wr_soft_reset) begin
                    if (key_value == `KEY_SECOND) begin
                        soft_reset_next = 1'b1;
                        key_next        = adc_ctrl_pkg::KEY_IDLE;
                    end else if (key_value != `KEY_FIRST) begin
                        key_next = adc_ctrl_pkg::KEY_IDLE;
                    end
                end
            end

            default: begin
                key_next = adc_ctrl_pkg::KEY_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_reg        <= adc_ctrl_pkg::KEY_IDLE;
            soft_reset_reg <= 1'b0;
        end else begin
            key_reg        <= key_next;
            soft_reset_reg <= soft_reset_next;
        end
    end

    // ------------------------------------------------------------------------
    // initialisation timer
    // ------------------------------------------------------------------------
    init_timer #(
        .CYCLES     (INIT_CYCLES)
    ) u_init_timer (
        .pclk       (pclk),
        .presetn    (presetn),
        .start      (soft_reset_reg),
        .busy       (init_busy_w),
        .done_pulse (init_done_w)
    );

    wire start_blocked = init_busy_w || soft_reset_reg;

    assign conv_start_grant     = conv_start_req && !start_blocked;

    assign converter_soft_reset = soft_reset_reg;

    assign init_busy            = init_busy_w;

    // ------------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------------
    assign dma_trigger_next  = wr_dma  ? pwdata[`DMA_FIELD_MSB:0] : dma_trigger_reg;

    assign mon0_control_next = wr_mon0 ? {pwdata[`MON_CNT_MSB:`MON_CNT_LSB],
                                          pwdata[`MON_EN_BIT], 2'b00,
                                          pwdata[`MON_SEL_BIT:`MON_CHAN_LSB]}
                                       : mon0_control_reg;

    assign irq_mask_next     = wr_mask ? pwdata[`IRQ_BITS-1:0] : irq_mask_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_trigger_reg  <= `RST_DMA_TRIGGER;
            mon0_control_reg <= `RST_MON0_CONTROL;
            irq_mask_reg     <= `RST_IRQ;
        end else begin
            dma_trigger_reg  <= dma_trigger_next;
            mon0_control_reg <= mon0_control_next;
            irq_mask_reg     <= irq_mask_next;
        end
    end

    // ------------------------------------------------------------------------
    // comparison monitor 0
    // ------------------------------------------------------------------------
    match_monitor #(
        .RESULT_W      (RESULT_W)
    ) u_match_monitor (
        .pclk          (pclk),
        .presetn       (presetn),
        .enable        (mon0_enable),
        .smaller_sel   (mon0_small_sel),
        .channel_sel   (mon0_chan_sel),
        .match_count   (mon0_match_cnt),
        .compare_value (compare_value),
        .repeat_mode   (repeat_mode_active),
        .clear         (soft_reset_reg),
        .ev            (conv_event),
        .count         (mon0_count_w),
        .hit_pulse     (mon0_hit_w)
    );

    assign monitor0_hit = mon0_hit_w;

    // ------------------------------------------------------------------------
    // dma request gating
    // ------------------------------------------------------------------------

    wire normal_event = conv_event.done && !conv_event.top_priority;

    wire top_event    = conv_event.done && conv_event.top_priority;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            normal_dma_reg <= 1'b0;
            top_dma_reg    <= 1'b0;
        end else begin
            normal_dma_reg <= normal_event && normal_dma_en;
            top_dma_reg    <= top_event && top_dma_en;
        end
    end

    assign normal_dma_req       = normal_dma_reg;

    assign top_priority_dma_req = top_dma_reg;

    // ------------------------------------------------------------------------
    // interrupt status, set wins over write-one-clear
    // ------------------------------------------------------------------------
    logic [`IRQ_BITS-1:0] irq_set;

    logic [`IRQ_BITS-1:0] irq_clr;

    always_comb begin
        irq_set                     = '0;

        irq_set[`IRQ_MATCH_BIT]     = mon0_hit_w;
        irq_set[`IRQ_INIT_DONE_BIT] = init_done_w;

        irq_clr                     = wr_status ? pwdata[`IRQ_BITS-1:0] : '0;
    end

    for (genvar i = 0; i < `IRQ_BITS; i++) begin : g_irq_bit
        assign irq_status_next[i] = irq_set[i] || (irq_status_reg[i] && !irq_clr[i]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= `RST_IRQ;
        end else begin
            irq_status_reg <= irq_status_next;
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // ------------------------------------------------------------------------
    // read data, captured in the setup cycle
    // ------------------------------------------------------------------------

    wire [31:0] rd_dma    = {28'h0, dma_trigger_reg};

    wire [31:0] rd_mon0   = {20'h0, mon0_control_reg};

    wire [31:0] rd_status = {30'h0, irq_status_reg};

    wire [31:0] rd_mask   = {30'h0, irq_mask_reg};

    wire [31:0] rd_state  = {23'h0, mon0_count_w, 2'b00,
                             (key_reg == adc_ctrl_pkg::KEY_ARMED), init_busy_w};

    wire [31:0] rd_mux    = hit_dma    ? rd_dma    :
                            hit_mon0   ? rd_mon0   :
                            hit_status ? rd_status :
                            hit_mask   ? rd_mask   :
                            hit_state  ? rd_state  : 32'h0;

    assign prdata_next = (setup_phase && !pwrite) ? rd_mux : prdata_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    // ------------------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------------------

    assign prdata  = prdata_reg;

    assign pready  = 1'b1;

    assign pslverr = access_phase && !mapped;

endmodule : adc_reset_dma_monitor_ctrl

/* logic/adc_ctrl_defines.svh */
// offsets, fields, reset values and timing of the converter control
// assumes 32-bit apb data, one aligned word per register, 40 mhz pclk
//
// Operation
// - key 10 then 01 triggers software reset
// - 3 us initialisation, conversion starts refused
// - bit 1 gates top-priority dma request
// - bit 0 gates normal dma request
// - match count field plus one matches needed
// - interrupt when match counter reaches count
// - bit 7 enables monitor comparisons and interrupt
// - clearing enable clears accumulated match count
// - compare selected channel result, count matches
// - channel codes 0 to 11 only valid
// - monitor works only in repeat modes
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

// ---------------------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------------------
`define OFS_SOFT_RESET      12'h000
`define OFS_DMA_TRIGGER     12'h004
`define OFS_MON0_CONTROL    12'h008
`define OFS_IRQ_STATUS      12'h00c
`define OFS_IRQ_MASK        12'h010
`define OFS_BLOCK_STATE     12'h014

// ---------------------------------------------------------------------------
// field positions and key values
// ---------------------------------------------------------------------------
`define KEY_LSB             0
`define KEY_MSB             1
`define KEY_FIRST           2'h2
`define KEY_SECOND          2'h1
`define DMA_NORMAL_BIT      0
`define DMA_TOP_BIT         1
`define DMA_FIELD_MSB       3
`define MON_CHAN_LSB        0
`define MON_CHAN_MSB        3
`define MON_SEL_BIT         4
`define MON_EN_BIT          7
`define MON_CNT_LSB         8
`define MON_CNT_MSB         11
`define MON_CHAN_LAST       4'hb
`define IRQ_MATCH_BIT       0
`define IRQ_INIT_DONE_BIT   1
`define IRQ_BITS            2

// ---------------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------------
`define RST_DMA_TRIGGER     4'h0
`define RST_MON0_CONTROL    12'h000
`define RST_IRQ             2'h0

// ---------------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------------
`define INIT_TIME_NS        3000
`define PCLK_PERIOD_NS      25
`define INIT_CYCLES         ((`INIT_TIME_NS + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS)

`endif

/* logic/adc_ctrl_pkg.sv */
// types shared by the converter control slice
// assumes a 12-bit conversion result by default
package adc_ctrl_pkg;

    // -----------------------------------------------------------------------
    // conversion completion event from the converter core
    // -----------------------------------------------------------------------
    typedef struct packed {
        logic        done;
        logic        top_priority;
        logic [3:0]  channel;
        logic [11:0] result;
    } conv_event_t;

    // -----------------------------------------------------------------------
    // software reset key sequencer
    // -----------------------------------------------------------------------
    typedef enum logic [0:0] {
        KEY_IDLE,
        KEY_ARMED
    } key_state_t;

endpackage : adc_ctrl_pkg

/* logic/init_timer.sv */
// initialisation timer started by a software reset
// assumes start is a one-cycle pulse on pclk
`include "adc_ctrl_defines.svh"
module init_timer #(
    parameter int CYCLES = `INIT_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic start,
    output logic      busy,
    output logic      done_pulse
);
    localparam int CW = $clog2(CYCLES + 1);

    if (CYCLES < 1) begin : g_bad_cycles
        $error("init_timer needs at least one cycle");
    end

    logic [CW-1:0] count_reg;
    logic          done_reg;
    wire           last = (count_reg == CW'(1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
            done_reg  <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (start) begin
                count_reg <= CW'(CYCLES);
            end else if (count_reg != '0) begin
                count_reg <= count_reg - CW'(1);
                done_reg  <= last;
            end
        end
    end

    assign busy       = (count_reg != '0);
    assign done_pulse = done_reg;
endmodule : init_timer

/* logic/match_monitor.sv */
// comparison monitor: counts matching results of one channel
// assumes one conversion event per completion, held for one cycle
`include "adc_ctrl_defines.svh"
module match_monitor #(
    parameter int RESULT_W = 12
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      enable,
    input  wire logic                      smaller_sel,
    input  wire logic [3:0]                channel_sel,
    input  wire logic [3:0]                match_count,
    input  wire logic [RESULT_W-1:0]       compare_value,
    input  wire logic                      repeat_mode,
    input  wire logic                      clear,
    input  wire adc_ctrl_pkg::conv_event_t ev,
    output logic [4:0]                     count,
    output logic                           hit_pulse
);
    if (RESULT_W < 1 || RESULT_W > 12) begin : g_bad_width
        $error("match_monitor result width must be 1 to 12");
    end

    logic [4:0] count_reg;
    logic       hit_reg;

    wire [RESULT_W-1:0] res      = ev.result[RESULT_W-1:0];
    wire chan_ok   = (channel_sel <= `MON_CHAN_LAST);
    wire sample    = ev.done && (ev.channel == channel_sel) && chan_ok;
    wire active    = enable && repeat_mode && sample;
    wire is_match  = smaller_sel ? (res < compare_value)
                                 : (res > compare_value);
    wire [4:0] target = {1'b0, match_count} + 5'h01;
    wire [4:0] bumped = count_reg + 5'h01;
    wire reached   = active && is_match && (bumped == target);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= 5'h00;
            hit_reg   <= 1'b0;
        end else begin
            hit_reg <= reached;
            if (!enable || clear) begin
                count_reg <= 5'h00;
            end else if (reached) begin
                count_reg <= 5'h00;
            end else if (active && is_match) begin
                count_reg <= bumped;
            end
        end
    end

    assign count     = count_reg;
    assign hit_pulse = hit_reg;
endmodule : match_monitor

/* tb/adc_ctrl_asserts.sv */
// port assertions for the converter control slice
// assumes one pclk domain, presetn asynchronous active low
module adc_ctrl_asserts #(
    parameter int INIT_CYCLES = 120
) (
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [11:0]               paddr,
    input wire logic [31:0]               pwdata,
    input wire adc_ctrl_pkg::conv_event_t conv_event,
    input wire logic                      conv_start_grant,
    input wire logic                      converter_soft_reset,
    input wire logic                      init_busy,
    input wire logic                      normal_dma_req,
    input wire logic                      top_priority_dma_req,
    input wire logic                      monitor0_hit
);
    timeunit 1ns / 100ps;
    // ------------
    // port checks
    // ------------
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    int busy_len;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            busy_len <= 0;
        else
            busy_len <= init_busy ? busy_len + 1 : 0;
    end
    a_grant_blocked: assert property (init_busy |-> !conv_start_grant)
        else $error("grant in init");
    a_busy_follows: assert property (converter_soft_reset |=> init_busy)
        else $error("no busy");
    a_busy_length: assert property ($fell(init_busy) |-> busy_len == INIT_CYCLES)
        else $error("busy length");
    a_key_pulse: assert property (converter_soft_reset |-> $past(psel && penable
        && pwrite && paddr == 12'h000 && pwdata[1:0] == 2'h1)) else $error("stray reset");
    a_pulse_single: assert property (converter_soft_reset |=> !converter_soft_reset)
        else $error("long pulse");
    a_norm_dma: assert property (normal_dma_req |-> $past(conv_event.done
        && !conv_event.top_priority)) else $error("stray normal req");
    a_top_dma: assert property (top_priority_dma_req |-> $past(conv_event.done
        && conv_event.top_priority)) else $error("stray top req");
    a_hit_single: assert property (monitor0_hit |=> !monitor0_hit)
        else $error("long hit");
endmodule : adc_ctrl_asserts

bind adc_reset_dma_monitor_ctrl adc_ctrl_asserts #(.INIT_CYCLES(INIT_CYCLES)) u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .conv_event,
    .conv_start_grant, .converter_soft_reset, .init_busy, .normal_dma_req,
    .top_priority_dma_req, .monitor0_hit);

/* tb/conv_core_model.sv */
// converter core and dma controller stand-in
// assumes fire is a one-cycle pulse
module conv_core_model (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 fire,
    input  wire logic                 fire_top,
    input  wire logic [3:0]           fire_ch,
    input  wire logic [11:0]          fire_res,
    input  wire logic                 normal_dma_req,
    input  wire logic                 top_priority_dma_req,
    output adc_ctrl_pkg::conv_event_t ev,
    output int                        n_norm,
    output int                        n_top
);
    timeunit 1ns / 100ps;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev <= '0;
            n_norm <= 0;
            n_top <= 0;
        end else begin
            ev <= fire ? {1'b1, fire_top, fire_ch, fire_res} : {1'b0, ~ev[15:0]};
            n_norm <= n_norm + int'(normal_dma_req);
            n_top <= n_top + int'(top_priority_dma_req);
        end
    end
endmodule : conv_core_model

/* tb/adc_reset_dma_monitor_ctrl_tb_top.sv */
// self-checking bench for the converter control slice
// assumes package and header compiled first
module adc_reset_dma_monitor_ctrl_tb_top;
    timeunit 1ns / 100ps;
    localparam int INIT = 4;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, repeat_mode_active;
    logic        conv_start_req, conv_start_grant, converter_soft_reset, init_busy, irq;
    logic        normal_dma_req, top_priority_dma_req, monitor0_hit, fire, fire_top, err;
    logic [3:0]  fire_ch;
    logic [11:0] paddr, compare_value, fire_res;
    logic [31:0] pwdata, prdata, rd;
    int          hits, miscompares, n_compared, n_norm, n_top;
    adc_ctrl_pkg::conv_event_t conv_event;
    adc_reset_dma_monitor_ctrl #(.INIT_CYCLES(INIT)) DUT (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .conv_event, .repeat_mode_active,
        .compare_value, .conv_start_req, .conv_start_grant, .converter_soft_reset, .init_busy,
        .normal_dma_req, .top_priority_dma_req, .monitor0_hit, .irq);
    conv_core_model u_core (.pclk, .presetn, .fire, .fire_top, .fire_ch, .fire_res,
        .normal_dma_req, .top_priority_dma_req, .ev(conv_event), .n_norm, .n_top);
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) if (monitor0_hit === 1'b1) hits <= hits + 1;
    // ------------
    // helpers
    // ------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic send(input logic t, input logic [3:0] c, input logic [11:0] r, input logic m);
        @(posedge pclk);
        fire <= 1'b1;
        fire_top <= t;
        fire_ch <= c;
        fire_res <= r;
        repeat_mode_active <= m;
        @(posedge pclk);
        fire <= 1'b0;
        @(posedge pclk);
    endtask : send
    function automatic logic is_match(input logic s, input logic [11:0] r, input logic [11:0] c);
        return s ? (r < c) : (r > c);
    endfunction : is_match
    task automatic stop_test();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        stop_test();
    end
    // ------------
    // tests
    // ------------
    initial begin
        int n, h0, nm, eh;
        logic [3:0] cnt, ch, ec;
        logic sel, m;
        logic [11:0] res;
        {pclk, presetn, psel, penable, pwrite, fire, fire_top, conv_start_req} = '0;
        {paddr, pwdata, compare_value, fire_ch, fire_res, hits} = '0;
        repeat_mode_active = 1'b1;
        void'($urandom(28257));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 12'h004, 0);
        chk(rd, 0);
        apb(0, 12'h008, 0);
        chk(rd, 0);
        apb(0, 12'h018, 0);
        chk({rd[30:0], err}, 1);
        $display("test registers done");
        apb(1, 12'h010, 3);
        conv_start_req <= 1'b1;
        apb(1, 12'h000, 2);
        apb(1, 12'h000, 1);
        repeat (2) @(posedge pclk);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (init_busy === 1'b1);
        chk(32'(n), INIT);
        chk(32'(conv_start_grant), 1);
        apb(0, 12'h00c, 0);
        chk(32'(rd[1:0]), 2);
        chk(32'(irq), 1);
        apb(1, 12'h00c, 2);
        @(posedge pclk);
        chk(32'(irq), 0);
        apb(1, 12'h000, 2);
        apb(1, 12'h000, 3);
        apb(1, 12'h000, 1);
        repeat (3) @(posedge pclk);
        chk(32'(init_busy), 0);
        $display("test soft reset done");
        for (int en = 0; en < 4; en++) begin
            for (int t = 0; t < 2; t++) begin
                n = n_norm;
                h0 = n_top;
                apb(1, 12'h004, 32'(en));
                send(1'(t), 4'($urandom_range(0, 11)), 12'($urandom()), 1'b1);
                repeat (2) @(posedge pclk);
                chk(32'(n_norm - n), 32'(en[0] && t == 0));
                chk(32'(n_top - h0), 32'(en[1] && t == 1));
            end
        end
        $display("test dma done");
        for (int k = 0; k < 6; k++) begin
            cnt = (k == 0) ? 4'hf : 4'($urandom_range(0, 3));
            ch = 4'($urandom_range(0, 11));
            sel = 1'($urandom());
            compare_value <= 12'($urandom());
            {h0, nm, eh} = {hits, 64'h0};
            apb(1, 12'h008, {20'h0, cnt, k != 1, 2'b00, sel, ch});
            repeat (k == 0 ? 120 : 16) begin
                ec = $urandom_range(0, 1) ? ch : 4'($urandom_range(0, 11));
                res = $urandom_range(0, 3) == 0 ? compare_value : 12'($urandom());
                m = $urandom_range(0, 7) != 0;
                send(0, ec, res, m);
                if (k != 1 && m && ec == ch && is_match(sel, res, compare_value)) begin
                    nm++;
                    if (nm == cnt + 1) begin
                        eh++;
                        nm = 0;
                    end
                end
            end
            repeat (3) @(posedge pclk);
            chk(32'(hits - h0), 32'(eh));
            apb(0, 12'h014, 0);
            chk(32'(rd[8:4]), 32'(nm));
            apb(0, 12'h00c, 0);
            chk(32'(rd[0]), 32'(eh != 0));
            apb(1, 12'h00c, 1);
            apb(1, 12'h008, 0);
            apb(0, 12'h014, 0);
            chk(32'(rd[8:4]), 0);
        end
        $display("test monitor done");
        stop_test();
    end
endmodule : adc_reset_dma_monitor_ctrl_tb_top
